// ---- ecr_control_register.sv ----
// serial register slave holding the acquisition control register and its decoded controls
// assumes: csN, sclk and sdi are synchronous to mclk and sclk is well below mclk/4
`include "ecr_defines.svh"
module ecr_control_register (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic [2:0] channelPowerOn,
    output logic [2:0] channelInputHiZ,
    output logic inputTopologySelect,
    output logic [1:0] preampGain,
    output logic referenceBufferOn,
    output logic clockFromPin,
    output logic crystalOscillatorOn,
    output logic gangActive,
    output logic gangMaster,
    output logic syncGangOe,
    output logic clkIoActive,
    output logic highRateSelect,
    output logic conversionRun,
    output logic powerOn,
    output logic softResetPending
);
    import ecr_pkg::*;

    ecr_regs_t q;
    ecr_regs_t d;
    logic rise;
    logic fall;
    logic [31:0] shifted;
    logic headDone;
    logic wordDone;
    logic wordWrite;
    logic [6:0] wordAddr;

    localparam ecr_regs_t REGS_RESET = '{
        state: ST_IDLE,
        ctl: `ECR_ACQ_CTL_RESET,
        shiftIn: 32'h00000000,
        shiftOut: 24'h000000,
        bitCnt: 5'h00,
        sclkPrev: 1'b0,
        sdo: 1'b0,
        readCtl: 1'b0
    };

    assign rise = sclk & ~q.sclkPrev;
    assign fall = ~sclk & q.sclkPrev;
    assign shifted = {q.shiftIn[30:0], sdi};
    assign headDone = ce & ~csN & rise & (q.state == ST_HEAD) & (q.bitCnt == 5'h07);
    assign wordDone = ce & ~csN & rise & (q.state == ST_DATA) & (q.bitCnt == 5'h1f);
    assign wordWrite = shifted[`ECR_WRITE_BIT]; // [RULE_18]
    assign wordAddr = shifted[`ECR_ADDR_MSB:`ECR_ADDR_LSB]; // [RULE_18]

    always_comb begin
        d = q;
        d.sclkPrev = sclk;
        unique case (q.state)
            ST_IDLE: begin
                d.bitCnt = 5'h00;
                d.sdo = 1'b0;
                if (!csN) begin
                    d.state = ST_HEAD;
                end
            end
            ST_HEAD: begin
                if (csN) begin
                    d.state = ST_IDLE;
                    d.sdo = 1'b0;
                end else begin
                    if (fall) begin
                        d.sdo = 1'b0;
                    end
                    if (rise) begin
                        d.shiftIn = shifted;
                        d.bitCnt = q.bitCnt + 5'h01;
                        if (q.bitCnt == 5'h07) begin
                            // address is known after the eighth bit, so read data follows in-word
                            d.state = ST_DATA;
                            d.readCtl = ~shifted[7] & (shifted[6:0] == `ECR_ADDR_ACQ_CTL);
                            d.shiftOut = d.readCtl ? q.ctl : 24'h000000;
                        end
                    end
                end
            end
            ST_DATA: begin
                if (csN) begin
                    // a word cut short is dropped whole, nothing half-written
                    d.state = ST_IDLE;
                    d.sdo = 1'b0;
                end else begin
                    if (fall) begin
                        d.sdo = q.shiftOut[23]; // [RULE_18]
                        d.shiftOut = {q.shiftOut[22:0], 1'b0};
                    end
                    if (rise) begin
                        d.shiftIn = shifted;
                        d.bitCnt = q.bitCnt + 5'h01;
                        if (q.bitCnt == 5'h1f) begin
                            // chip select may stay low, so the next word starts at once
                            d.state = ST_HEAD;
                            d.bitCnt = 5'h00;
                            if (wordWrite && wordAddr == `ECR_ADDR_ACQ_CTL) begin
                                // reserved bits are masked so they read back as zero
                                d.ctl = shifted[23:0] & `ECR_ACQ_CTL_WMASK;
                            end else if (!wordWrite && wordAddr == `ECR_ADDR_NOP
                                         && q.ctl[`ECR_SOFTRST]) begin
                                d.ctl = `ECR_ACQ_CTL_RESET; // [RULE_15] [RULE_16] [RULE_17]
                            end
                        end
                    end
                end
            end
        endcase
    end

    // power state never touches ctl, so contents survive power down
    always_ff @(posedge mclk) begin
        if (srst) begin
            q <= REGS_RESET;
        end else if (ce) begin
            q <= d; // [RULE_14]
        end
    end

    assign sdo = q.sdo;
    assign powerOn = q.ctl[`ECR_POWER];
    assign channelPowerOn = q.ctl[`ECR_CHAN_MSB:`ECR_CHAN_LSB] & {3{powerOn}}; // [RULE_01]
    assign channelInputHiZ = ~channelPowerOn; // [RULE_01]
    assign inputTopologySelect = q.ctl[`ECR_TOPOLOGY]; // [RULE_02]
    assign preampGain = q.ctl[`ECR_GAIN_MSB:`ECR_GAIN_LSB]; // [RULE_03]
    assign referenceBufferOn = q.ctl[`ECR_REFBUF];
    assign gangActive = q.ctl[`ECR_GANG]; // [RULE_10]
    assign gangMaster = gangActive & q.ctl[`ECR_MASTER]; // [RULE_08] [RULE_09]
    assign syncGangOe = gangMaster; // [RULE_08]
    assign clkIoActive = gangActive; // [RULE_10]
    assign clockFromPin = q.ctl[`ECR_EXTCLK] | (gangActive & ~gangMaster); // [RULE_06] [RULE_07]
    assign crystalOscillatorOn = powerOn & ~clockFromPin; // [RULE_06] [RULE_07] [RULE_13]
    assign highRateSelect = q.ctl[`ECR_HIRATE]; // [RULE_11]
    assign conversionRun = q.ctl[`ECR_CONVERT] & powerOn; // [RULE_12] [RULE_13]
    assign softResetPending = q.ctl[`ECR_SOFTRST];

    sequence s_ctl_write;
        wordDone && wordWrite && wordAddr == `ECR_ADDR_ACQ_CTL;
    endsequence
    sequence s_nop_finish;
        wordDone && !wordWrite && wordAddr == `ECR_ADDR_NOP && q.ctl[`ECR_SOFTRST];
    endsequence
    sequence s_read_head;
        headDone && !shifted[7] && shifted[6:0] == `ECR_ADDR_ACQ_CTL;
    endsequence
    sequence s_head_other;
        headDone && (shifted[7] || shifted[6:0] != `ECR_ADDR_ACQ_CTL);
    endsequence
    sequence s_data_fall;
        ce && !csN && fall && q.state == ST_DATA;
    endsequence
    sequence s_other_write;
        wordDone && wordWrite && wordAddr != `ECR_ADDR_ACQ_CTL;
    endsequence
    sequence s_cut_word;
        ce && csN && q.state == ST_DATA;
    endsequence

    a_write_ctl: assert property (@(posedge mclk) disable iff (srst) // [RULE_18]
        s_ctl_write |=> q.ctl == ($past(shifted[23:0]) & `ECR_ACQ_CTL_WMASK))
        else $error("control write not stored");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (srst) // [RULE_18]
        q.ctl[`ECR_RSVD_MSB:`ECR_RSVD_LSB] == 10'h000)
        else $error("reserved bits not zero");
    a_soft_reset: assert property (@(posedge mclk) disable iff (srst) // [RULE_15]
        s_nop_finish |=> q.ctl == `ECR_ACQ_CTL_RESET && !softResetPending)
        else $error("soft reset did not restore defaults");
    a_ctl_retain: assert property (@(posedge mclk) disable iff (srst) // [RULE_14]
        !$stable(q.ctl) |-> $past(wordDone) || $past(srst))
        else $error("control changed without a command");
    a_slave_clock: assert property (@(posedge mclk) disable iff (srst) // [RULE_07]
        gangActive && !q.ctl[`ECR_MASTER] |-> clockFromPin && !crystalOscillatorOn)
        else $error("gang slave still on crystal");
    a_master_ignored: assert property (@(posedge mclk) disable iff (srst) // [RULE_09]
        !q.ctl[`ECR_GANG] |-> !syncGangOe && !gangMaster && !clkIoActive)
        else $error("master bit acted outside gang mode");
    a_read_load: assert property (@(posedge mclk) disable iff (srst) // [RULE_18]
        s_read_head |=> q.shiftOut == $past(q.ctl) && q.state == ST_DATA)
        else $error("read data not loaded");
    a_power_down: assert property (@(posedge mclk) disable iff (srst) // [RULE_13]
        !powerOn |-> channelPowerOn == 3'b000 && !crystalOscillatorOn && !conversionRun)
        else $error("analog active while powered down");
    a_frame_abort: assert property (@(posedge mclk) disable iff (srst) // [RULE_18]
        ce && csN |=> q.state == ST_IDLE && q.sdo == 1'b0)
        else $error("frame not abandoned on deselect");

    a_ce_freeze: assert property (@(posedge mclk) disable iff (srst) // [RULE_14]
        !ce |=> $stable(q))
        else $error("state moved while clock enable low");
    a_read_other: assert property (@(posedge mclk) disable iff (srst) // [RULE_18]
        s_head_other |=> q.shiftOut == 24'h000000)
        else $error("read of other address not zero");
    a_sdo_shift: assert property (@(posedge mclk) disable iff (srst) // [RULE_18]
        s_data_fall |=> sdo == $past(q.shiftOut[23]))
        else $error("read bit not shifted out");
    a_write_other: assert property (@(posedge mclk) disable iff (srst) // [RULE_18]
        s_other_write |=> $stable(q.ctl))
        else $error("write to other address changed control");
    a_cut_word: assert property (@(posedge mclk) disable iff (srst) // [RULE_18]
        s_cut_word |=> $stable(q.ctl))
        else $error("cut word changed control");
    a_sdo_quiet: assert property (@(posedge mclk) disable iff (srst) // [RULE_18]
        q.state == ST_IDLE |-> !sdo)
        else $error("serial out active while idle");
    a_ext_clock: assert property (@(posedge mclk) disable iff (srst) // [RULE_06]
        q.ctl[`ECR_EXTCLK] |-> clockFromPin && !crystalOscillatorOn)
        else $error("external clock not selected");
    a_master_sync: assert property (@(posedge mclk) disable iff (srst) // [RULE_08]
        gangActive && q.ctl[`ECR_MASTER] |-> syncGangOe && gangMaster && clkIoActive)
        else $error("gang master not driving sync pin");
    a_convert_run: assert property (@(posedge mclk) disable iff (srst) // [RULE_12]
        q.ctl[`ECR_CONVERT] && powerOn |-> conversionRun)
        else $error("conversion not running");
    a_chan_on: assert property (@(posedge mclk) disable iff (srst) // [RULE_01]
        powerOn |-> channelPowerOn == q.ctl[`ECR_CHAN_MSB:`ECR_CHAN_LSB])
        else $error("channel enable not applied");
endmodule

// ---- ecr_defines.svh ----
// constants for the acquisition control register block
// assumes: included once per compile unit, by bare name
// Summary of operation
// RULE_01: channel enable bits power channels, else high-Z
// RULE_02: bit 10 picks single-ended or differential inputs
// RULE_03: bits 9:8 pick preamp gain code
// RULE_04: host calibrates gain before using code 11
// RULE_05: host enables reference buffer with internal reference
// RULE_06: bit 6 picks crystal or external clock
// RULE_07: gang slave drops crystal, takes master clock
// RULE_08: bit 5 makes gang master, drives sync pin
// RULE_09: master bit ignored outside gang mode
// RULE_10: bit 4 enables gang, activates clock/sync pins
// RULE_11: bit 3 picks 1 or 2 MSPS rate
// RULE_12: bit 2 starts conversions and filters
// RULE_13: bit 1 low powers down analog and crystal
// RULE_14: contents kept unchanged during power down
// RULE_15: soft reset restores register to reset value
// RULE_16: soft reset bit clears itself
// RULE_17: host sends no-operation command to finish reset
// RULE_18: 32-bit word: write flag, 7-bit address, 24 data
`ifndef ECR_DEFINES_SVH
`define ECR_DEFINES_SVH
`define ECR_WORD_BITS 32
`define ECR_HEAD_BITS 8
`define ECR_WRITE_BIT 31
`define ECR_ADDR_MSB 30
`define ECR_ADDR_LSB 24
`define ECR_ADDR_NOP 7'h00
`define ECR_ADDR_ACQ_CTL 7'h01
`define ECR_ACQ_CTL_RESET 24'h000000
`define ECR_ACQ_CTL_WMASK 24'he007ff
`define ECR_CHAN_MSB 23
`define ECR_CHAN_LSB 21
`define ECR_RSVD_MSB 20
`define ECR_RSVD_LSB 11
`define ECR_TOPOLOGY 10
`define ECR_GAIN_MSB 9
`define ECR_GAIN_LSB 8
`define ECR_REFBUF 7
`define ECR_EXTCLK 6
`define ECR_MASTER 5
`define ECR_GANG 4
`define ECR_HIRATE 3
`define ECR_CONVERT 2
`define ECR_POWER 1
`define ECR_SOFTRST 0
`endif

// ---- ecr_host_model.sv ----
// host model driving the serial register link
// assumes: dut samples sclk on mclk, two or more mclk per phase
module ecr_host_model (
    input wire logic mclk,
    output logic csN,
    output logic sclk,
    output logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // sclk idles low; sdi flips once released so nothing leans on it
    // hold keeps select low so the next word follows back to back
    task automatic xfer(input logic [31:0] w, input int n, input bit hold,
                        output logic [23:0] rd);
        rd = '0;
        if (csN) begin
            @(posedge mclk) csN <= 1'b0;
            repeat (2) @(posedge mclk);
        end
        for (int i = 31; i > 31 - n; i--) begin
            sclk <= 1'b0;
            sdi <= w[i];
            repeat (3) @(posedge mclk);
            sclk <= 1'b1;
            if (i < 24) rd[i] = sdo;
            repeat (2) @(posedge mclk);
        end
        sclk <= 1'b0;
        repeat (2) @(posedge mclk);
        if (!hold) begin
            csN <= 1'b1;
            sdi <= ~sdi;
            repeat (2) @(posedge mclk);
        end
    endtask
endmodule

// ---- ecr_pkg.sv ----
// types shared by the acquisition control register block
// assumes: compiled before any module that imports it
package ecr_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HEAD = 3'b010,
        ST_DATA = 3'b100
    } ecr_state_t;

    typedef struct packed {
        ecr_state_t state;
        logic [23:0] ctl;
        logic [31:0] shiftIn;
        logic [23:0] shiftOut;
        logic [4:0] bitCnt;
        logic sclkPrev;
        logic sdo;
        logic readCtl;
    } ecr_regs_t;
endpackage

// ---- tb_top.sv ----
// self-checking bench for the acquisition control register
// assumes: host model owns the link, ce stays high except during the frozen-block word
`include "ecr_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic csN, sclk, sdi, sdo;
    wire [19:0] outs;
    logic [23:0] rdv;
    logic [23:0] pat [4] = '{24'hfffffe, 24'h400210, 24'ha0012a, 24'h000494};
    int miscompares = 0;
    int n_compared = 0;
    always #25 mclk = ~mclk;
    ecr_control_register i_dut (.mclk(mclk), .srst(srst), .ce(ce), .csN(csN),
        .sclk(sclk), .sdi(sdi), .sdo(sdo), .channelPowerOn(outs[19:17]),
        .channelInputHiZ(outs[16:14]), .inputTopologySelect(outs[13]),
        .preampGain(outs[12:11]), .referenceBufferOn(outs[10]), .clockFromPin(outs[9]),
        .crystalOscillatorOn(outs[8]), .gangActive(outs[7]), .gangMaster(outs[6]),
        .syncGangOe(outs[5]), .clkIoActive(outs[4]), .highRateSelect(outs[3]),
        .conversionRun(outs[2]), .powerOn(outs[1]), .softResetPending(outs[0]));
    ecr_host_model i_host (.mclk(mclk), .csN(csN), .sclk(sclk), .sdi(sdi), .sdo(sdo));
    task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // expected levels worked out from the stored control word
    task automatic chkOut(input logic [23:0] c);
        logic [2:0] ch;
        logic pin;
        ch = c[23:21] & {3{c[1]}};
        pin = c[6] | (c[4] & ~c[5]);
        cmp("outputs", {4'h0, ch, ~ch, c[10], c[9:8], c[7], pin, c[1] & ~pin, c[4],
            c[4] & c[5], c[4] & c[5], c[4], c[3], c[2] & c[1], c[1], c[0]}, {4'h0, outs});
    endtask
    task automatic wr(input logic [6:0] a, input logic [23:0] d);
        i_host.xfer({1'b1, a, d}, 32, 1'b0, rdv);
    endtask
    task automatic rdChk(input logic [6:0] a, input logic [23:0] exp);
        i_host.xfer({1'b0, a, 24'h0}, 32, 1'b0, rdv);
        cmp("read data", exp, rdv);
    endtask
    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        chkOut(24'h0);
        rdChk(7'h01, 24'h0);
        // gain 11 goes with the buffer on, calibration left to the host
        foreach (pat[k]) begin
            wr(7'h01, pat[k]);
            chkOut(pat[k]);
            chkOut(pat[k]);
            rdChk(7'h01, pat[k] & `ECR_ACQ_CTL_WMASK);
        end
        wr(7'h05, 24'h123456);
        chkOut(pat[3]);
        rdChk(7'h05, 24'h0);
        i_host.xfer({1'b1, 7'h01, 24'hffffff}, 12, 1'b0, rdv);
        chkOut(pat[3]);
        wr(7'h01, 24'h20000b);
        chkOut(24'h20000b);
        rdChk(7'h01, 24'h20000b);
        rdChk(7'h00, 24'h0);
        chkOut(24'h0);
        rdChk(7'h01, 24'h0);
        i_host.xfer({1'b1, 7'h01, pat[1]}, 32, 1'b1, rdv);
        rdChk(7'h01, pat[1] & `ECR_ACQ_CTL_WMASK);
        chkOut(pat[1]);
        // a frozen block must ignore a whole word
        ce <= 1'b0;
        wr(7'h01, 24'h000002);
        ce <= 1'b1;
        chkOut(pat[1]);
        rdChk(7'h01, pat[1] & `ECR_ACQ_CTL_WMASK);
        wr(7'h01, pat[2]);
        @(posedge mclk) srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        chkOut(24'h0);
        rdChk(7'h01, 24'h0);
        wrap_up();
    end
endmodule
